// ---- hw/duc_defines.svh ----
`ifndef DUC_DEFINES_SVH
`define DUC_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DUC_ADDR_W          7
`define DUC_OFS_SYNC        7'h15
`define DUC_OFS_SWCLAMP     7'h17
`define DUC_OFS_SB_A        7'h18
`define DUC_OFS_SB_B        7'h19
`define DUC_OFS_ALARM       7'h1a
`define DUC_OFS_TRIG        7'h1c
`define DUC_OFS_CODE_FIRST  7'h30
`define DUC_OFS_CODE_LAST   7'h37

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DUC_NUM_TGT         6
`define DUC_TGT_PAIR_A      0
`define DUC_TGT_PAIR_B      1
`define DUC_TGT_AUX_FIRST   2
`define DUC_DEFER_BIT       7
`define DUC_TRIG_DAC_BIT    0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DUC_RST_SYNC        8'h00
`define DUC_RST_SWCLAMP     6'h3f
`define DUC_RST_MASK        8'h00
`define DUC_RST_ALARM       6'h00
`define DUC_RST_CODE        12'h000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DUC_SYNC_STAGES     2

`endif

// ---- hw/duc_pkg.sv ----
package duc_pkg;

    // decoded access from the serial register front end
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [15:0] wdata;
    } duc_req_t;

    // per-channel drive to the analog converter
    typedef struct packed {
        logic        clamp;
        logic        rail;
        logic [11:0] code;
    } duc_chan_t;

endpackage

// ---- hw/duc_core.sv ----
`timescale 1ns/1ns
// Contract
// - eight 12-bit data registers at consecutive addresses 0x30 to 0x37
// - codes are straight binary, no conversion applied to stored values
// - host writes land in the channel buffer register first
// - the sync register picks asynchronous or synchronous transfer per channel
// - asynchronous: a data write also loads the active register at once
// - synchronous: active register loads only on a converter trigger
// - trigger comes from the trigger register bit or the trigger pin
// - reading a data register returns the active code, not the buffer
// - clamping drives the clamp level and leaves buffer and active untouched
// - data writes are accepted while clamped
// - leaving clamp outputs the active code at once in either mode
// - software clamp register: one bit per pair and per aux channel
// - pair A uses clamp level pin A, pair B pin B, aux use ground
// - supply fault puts all bipolar channels in negative rail clamp
// - while a standby pin forces a target, its clamp bit writes are ignored
// - two standby masks select targets clamped by each standby pin
// - standby pins and masks also drive the amplifier enable pin
// - standby pin high clamps masked targets immediately
// - deferred release: clamp holds until pin low then host writes 0
// - without deferred release, pin low releases the clamp at once
// - alarm mask selects targets clamped when the alarm output is active
// - alarm going inactive does not release its clamp
// - after reset every channel is clamped and codes take defaults
// - bipolar channels form pairs 0-1 and 2-3 sharing clamp control
`include "duc_defines.svh"

module duc_core
    import duc_pkg::*;
#(
    parameter int NUM_CH = 8,
    parameter int CODE_W = 12
)(
    // clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    // register access
    input  wire duc_req_t  reg_req_i,
    output logic [15:0]    reg_rdata_o,
    output logic           reg_rvalid_o,
    // pins
    input  wire logic      converter_update_pin_i,
    input  wire logic      standby_pin_a_i,
    input  wire logic      standby_pin_b_i,
    input  wire logic      alarm_output_pin_i,
    input  wire logic      supply_fault_i,
    output logic           amp_enable_pin_o,
    // converter drive
    output duc_chan_t      chan_o [NUM_CH]
);

    // the target map and read path are built for exactly eight 12-bit channels
    if (NUM_CH != 8 || CODE_W != 12)
    begin : g_bad_param
        $error("duc_core serves exactly eight 12-bit channels");
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int NPIN = 5;
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;
    logic            trig_pin_s;
    logic            sb_a_s;
    logic            sb_b_s;
    logic            alarm_s;
    logic            fault_s;
    logic            trig_pin_d;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= {supply_fault_i, alarm_output_pin_i, standby_pin_b_i,
                         standby_pin_a_i, converter_update_pin_i};
            pin_sync <= pin_meta;
        end
    end

    assign trig_pin_s = pin_sync[0];
    assign sb_a_s     = pin_sync[1];
    assign sb_b_s     = pin_sync[2];
    assign alarm_s    = pin_sync[3];
    assign fault_s    = pin_sync[4];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            trig_pin_d <= 1'b0;
        else
            trig_pin_d <= trig_pin_s;
    end

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    logic [7:0] dac_update_mode_select;
    logic [5:0] software_clamp_control;
    logic [7:0] standby_a_clamp_mask;
    logic [7:0] standby_b_clamp_mask;
    logic [5:0] alarm_clamp_mask;
    logic       wr_sync;
    logic       wr_swclamp;
    logic       wr_trig;
    logic       code_hit;
    logic [2:0] code_idx;
    logic       dac_trigger;

    assign wr_sync    = reg_req_i.wr && reg_req_i.addr == `DUC_OFS_SYNC;
    assign wr_swclamp = reg_req_i.wr && reg_req_i.addr == `DUC_OFS_SWCLAMP;
    assign wr_trig    = reg_req_i.wr && reg_req_i.addr == `DUC_OFS_TRIG;
    assign code_hit   = reg_req_i.addr >= `DUC_OFS_CODE_FIRST
                     && reg_req_i.addr <= `DUC_OFS_CODE_LAST;
    assign code_idx   = reg_req_i.addr[2:0];

    // the trigger bit is a strobe; it is never stored
    assign dac_trigger = (wr_trig && reg_req_i.wdata[`DUC_TRIG_DAC_BIT])
                      || (trig_pin_s && !trig_pin_d);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dac_update_mode_select <= `DUC_RST_SYNC;
            standby_a_clamp_mask   <= `DUC_RST_MASK;
            standby_b_clamp_mask   <= `DUC_RST_MASK;
            alarm_clamp_mask       <= `DUC_RST_ALARM;
        end
        else if (reg_req_i.wr)
        begin
            case (reg_req_i.addr)
                `DUC_OFS_SYNC:  dac_update_mode_select <= reg_req_i.wdata[7:0];
                `DUC_OFS_SB_A:  standby_a_clamp_mask   <= reg_req_i.wdata[7:0];
                `DUC_OFS_SB_B:  standby_b_clamp_mask   <= reg_req_i.wdata[7:0];
                `DUC_OFS_ALARM: alarm_clamp_mask       <= reg_req_i.wdata[5:0];
                default:        ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // clamp resolution per target
    // ----------------------------------------------------------------
    logic [5:0] sb_live;
    logic [5:0] sb_hold;
    logic [5:0] alarm_hold;
    logic [5:0] tgt_clamp;
    logic [5:0] sb_a_force;
    logic [5:0] sb_b_force;

    assign sb_a_force = sb_a_s ? standby_a_clamp_mask[5:0] : 6'h00;
    assign sb_b_force = sb_b_s ? standby_b_clamp_mask[5:0] : 6'h00;
    assign sb_live    = sb_a_force | sb_b_force;

    // software bit: writes to a target forced by a live standby pin are dropped
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            software_clamp_control <= `DUC_RST_SWCLAMP;
        else if (wr_swclamp)
            software_clamp_control <= (reg_req_i.wdata[5:0] & ~sb_live)
                                    | (software_clamp_control & sb_live);
    end

    // deferred-release holds: set wins over the releasing write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sb_hold <= 6'h00;
        else
            sb_hold <= (standby_a_clamp_mask[`DUC_DEFER_BIT] ? sb_a_force : 6'h00)
                     | (standby_b_clamp_mask[`DUC_DEFER_BIT] ? sb_b_force : 6'h00)
                     | (sb_hold & ~(wr_swclamp ? ~reg_req_i.wdata[5:0] & ~sb_live
                                               : 6'h00));
    end

    // alarm holds survive the alarm going away until software releases them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            alarm_hold <= 6'h00;
        else
            alarm_hold <= (alarm_s ? alarm_clamp_mask : 6'h00)
                        | (alarm_hold & ~((wr_swclamp && !alarm_s)
                                          ? ~reg_req_i.wdata[5:0] : 6'h00));
    end

    // without deferral, only the live pin term is present, so pin low releases
    assign tgt_clamp = software_clamp_control | sb_live | sb_hold | alarm_hold;

    // amplifier off while any standby pin clamps a selected target
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            amp_enable_pin_o <= 1'b0;
        else
            amp_enable_pin_o <= !(|sb_live);
    end

    // ----------------------------------------------------------------
    // per channel buffer and active registers
    // ----------------------------------------------------------------
    logic [CODE_W-1:0] active_code [NUM_CH];

    function automatic int tgt_of(input int ch);
        if (ch < 2)
            return `DUC_TGT_PAIR_A;
        else if (ch < 4)
            return `DUC_TGT_PAIR_B;
        else
            return ch - 4 + `DUC_TGT_AUX_FIRST;
    endfunction

    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        logic [CODE_W-1:0] buffer_code;
        logic              wr_me;

        assign wr_me = reg_req_i.wr && code_hit && code_idx == 3'(g);

        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                buffer_code <= `DUC_RST_CODE;
            else if (wr_me)
                buffer_code <= reg_req_i.wdata[CODE_W-1:0];
        end

        // clamp state never gates these loads, so codes keep moving underneath
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                active_code[g] <= `DUC_RST_CODE;
            else if (!dac_update_mode_select[g] && wr_me)
                active_code[g] <= reg_req_i.wdata[CODE_W-1:0];
            else if (dac_update_mode_select[g] && dac_trigger)
                active_code[g] <= buffer_code;
        end

        // code is passed straight through; clamp only redirects the analog path
        always_comb
        begin
            chan_o[g].code  = active_code[g];
            chan_o[g].clamp = tgt_clamp[tgt_of(g)] || (g < 4 && fault_s);
            chan_o[g].rail  = (g < 4) && fault_s;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o  <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rvalid_o <= reg_req_i.rd;
            if (reg_req_i.rd)
            begin
                if (code_hit)
                    reg_rdata_o <= {4'h0, active_code[code_idx]};
                else
                begin
                    case (reg_req_i.addr)
                        `DUC_OFS_SYNC:    reg_rdata_o <= {8'h00, dac_update_mode_select};
                        `DUC_OFS_SWCLAMP: reg_rdata_o <= {10'h000, software_clamp_control};
                        `DUC_OFS_SB_A:    reg_rdata_o <= {8'h00, standby_a_clamp_mask};
                        `DUC_OFS_SB_B:    reg_rdata_o <= {8'h00, standby_b_clamp_mask};
                        `DUC_OFS_ALARM:   reg_rdata_o <= {10'h000, alarm_clamp_mask};
                        default:          reg_rdata_o <= 16'h0000;
                    endcase
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_async_write0;
        reg_req_i.wr && reg_req_i.addr == `DUC_OFS_CODE_FIRST && !dac_update_mode_select[0];
    endsequence

    property p_async_load;
        logic [11:0] d;
        (s_async_write0, d = reg_req_i.wdata[11:0]) |=> chan_o[0].code == d;
    endproperty
    a_async_load: assert property (p_async_load)
        else $error("asynchronous write did not reach the active code");

    property p_sync_hold;
        (reg_req_i.wr && code_hit && code_idx == 3'd0 && dac_update_mode_select[0]
         && !dac_trigger) |=> $stable(chan_o[0].code);
    endproperty
    a_sync_hold: assert property (p_sync_hold)
        else $error("synchronous write changed the active code");

    property p_trigger_load;
        (dac_update_mode_select[2] && dac_trigger && !(reg_req_i.wr && code_hit))
            |=> chan_o[2].code == $past(g_ch[2].buffer_code);
    endproperty
    a_trigger_load: assert property (p_trigger_load)
        else $error("trigger did not transfer the buffer");

    property p_read_active;
        (reg_req_i.rd && code_hit && code_idx == 3'd3)
            |=> reg_rvalid_o && reg_rdata_o == {4'h0, $past(active_code[3])};
    endproperty
    a_read_active: assert property (p_read_active)
        else $error("data read did not return the active code");

    property p_standby_clamp;
        (sb_a_s && standby_a_clamp_mask[`DUC_TGT_PAIR_A]) |-> chan_o[0].clamp && chan_o[1].clamp;
    endproperty
    a_standby_clamp: assert property (p_standby_clamp)
        else $error("standby pin did not clamp pair A");

    property p_forced_write_ignored;
        (wr_swclamp && sb_live[2] && !reg_req_i.wdata[2])
            |=> software_clamp_control[2] == $past(software_clamp_control[2]);
    endproperty
    a_forced_write_ignored: assert property (p_forced_write_ignored)
        else $error("clamp bit changed while standby forced it");

    sequence s_alarm_fall4;
        alarm_s && alarm_clamp_mask[1] ##1 (!alarm_s && !wr_swclamp) [*3];
    endsequence

    property p_alarm_sticks;
        s_alarm_fall4 |-> chan_o[2].clamp;
    endproperty
    a_alarm_sticks: assert property (p_alarm_sticks)
        else $error("alarm clamp released without a software write");

    property p_fault_rail;
        fault_s |-> chan_o[3].rail && chan_o[3].clamp && !chan_o[4].rail;
    endproperty
    a_fault_rail: assert property (p_fault_rail)
        else $error("supply fault did not force the bipolar rail clamp");

    property p_amp_off;
        (|sb_live) |=> !amp_enable_pin_o;
    endproperty
    a_amp_off: assert property (p_amp_off)
        else $error("amplifier enabled during standby clamp");

    property p_clamp_keeps_code;
        (chan_o[6].clamp && !(reg_req_i.wr && code_hit) && !dac_trigger)
            |=> $stable(chan_o[6].code);
    endproperty
    a_clamp_keeps_code: assert property (p_clamp_keeps_code)
        else $error("clamping disturbed the active code");

endmodule

// ---- test/duc_host.sv ----
`timescale 1ns/1ns
module duc_host
    import duc_pkg::*;
(
    // clock
    input  wire logic        clk_i,
    // register port
    output duc_req_t         req_o,
    input  wire logic [15:0] rdata_i,
    input  wire logic        rvalid_i
);

    initial req_o = '0;

    // ----------------------------------------
    // accesses
    // ----------------------------------------
    // strobes last one cycle; a spare edge between calls keeps two strobes apart
    task automatic wr(input logic [6:0] addr, input logic [15:0] data);
        @(posedge clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk_i);
        req_o <= '0;
    endtask

    task automatic rd(input logic [6:0] addr, output logic [15:0] data, output bit ok);
        int n;
        ok = 1'b0;
        data = '0;
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
        @(posedge clk_i);
        req_o <= '0;
        // bounded wait so a dead answer cannot hang the host
        for (n = 0; n < 4 && !ok; n++)
        begin
            @(negedge clk_i);
            if (rvalid_i === 1'b1)
            begin
                data = rdata_i;
                ok = 1'b1;
            end
        end
    endtask

endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ns
`include "duc_defines.svh"
module tb
    import duc_pkg::*;
;
    logic        clk_i;
    logic        rst_i;
    duc_req_t    req;
    logic [15:0] rdata;
    logic        rvalid;
    logic        upd_pin;
    logic        sb_a;
    logic        sb_b;
    logic        alarm;
    logic        fault;
    logic        amp_en;
    duc_chan_t   chan [8];
    int          err_total;
    int          total_checks;

    initial clk_i = 1'b0;
    always #50 clk_i = ~clk_i;

    duc_host u_host (
        .clk_i    (clk_i),
        .req_o    (req),
        .rdata_i  (rdata),
        .rvalid_i (rvalid)
    );

    duc_core #(.NUM_CH(8), .CODE_W(12)) u_dut (
        .clk_i                  (clk_i),
        .rst_i                  (rst_i),
        .reg_req_i              (req),
        .reg_rdata_o            (rdata),
        .reg_rvalid_o           (rvalid),
        .converter_update_pin_i (upd_pin),
        .standby_pin_a_i        (sb_a),
        .standby_pin_b_i        (sb_b),
        .alarm_output_pin_i     (alarm),
        .supply_fault_i         (fault),
        .amp_enable_pin_o       (amp_en),
        .chan_o                 (chan)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk_ch(input int ch, input logic cl, input logic rl, input logic [11:0] code);
        chk({2'b00, chan[ch].clamp, chan[ch].rail, chan[ch].code}, {2'b00, cl, rl, code});
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] d;
        bit          ok;
        u_host.rd(a, d, ok);
        if (ok)
            chk(d, exp);
        else
        begin
            $display("read timeout at %0t", $time);
            err_total++;
            end_sim();
        end
    endtask

    // pins pass a two-flop synchroniser, so allow a few edges before looking
    task automatic settle();
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    function automatic int tgt(input int ch);
        return (ch < 2) ? 0 : (ch < 4) ? 1 : ch - 2;
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        int ch;
        @(negedge clk_i);
        @(negedge clk_i);
        for (ch = 0; ch < 8; ch++)
            chk_ch(ch, 1'b1, 1'b0, 12'h000);
        chk({15'h0, amp_en}, 16'h0001);
        rchk(`DUC_OFS_SYNC, 16'h0000);
        rchk(`DUC_OFS_SWCLAMP, 16'h003f);
        rchk(`DUC_OFS_SB_A, 16'h0000);
        rchk(`DUC_OFS_SB_B, 16'h0000);
        rchk(`DUC_OFS_ALARM, 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_async();
        int          ch;
        logic [11:0] codes [8] = '{12'h000, 12'h001, 12'h800, 12'hffe,
                                   12'hfff, 12'h123, 12'h456, 12'h789};
        u_host.wr(`DUC_OFS_SWCLAMP, 16'h0000);
        rchk(`DUC_OFS_SWCLAMP, 16'h0000);
        for (ch = 0; ch < 8; ch++)
        begin
            u_host.wr(`DUC_OFS_CODE_FIRST | 7'(ch), {4'h0, codes[ch]});
            @(negedge clk_i);
            chk_ch(ch, 1'b0, 1'b0, codes[ch]);
            rchk(`DUC_OFS_CODE_FIRST | 7'(ch), {4'h0, codes[ch]});
        end
        rchk(7'h20, 16'h0000);
        $display("test async done");
    endtask

    task automatic t_sync();
        u_host.wr(`DUC_OFS_SYNC, 16'h000f);
        rchk(`DUC_OFS_SYNC, 16'h000f);
        u_host.wr(`DUC_OFS_CODE_FIRST, 16'h0abc);
        u_host.wr(`DUC_OFS_CODE_FIRST | 7'h4, 16'h0321);
        @(negedge clk_i);
        chk_ch(0, 1'b0, 1'b0, 12'h000);
        chk_ch(4, 1'b0, 1'b0, 12'h321);
        rchk(`DUC_OFS_CODE_FIRST, 16'h0000);
        u_host.wr(`DUC_OFS_TRIG, 16'h0001);
        @(negedge clk_i);
        chk_ch(0, 1'b0, 1'b0, 12'habc);
        rchk(`DUC_OFS_TRIG, 16'h0000);
        u_host.wr(`DUC_OFS_CODE_FIRST | 7'h2, 16'h0555);
        @(posedge clk_i);
        upd_pin <= 1'b1;
        settle();
        chk_ch(2, 1'b0, 1'b0, 12'h555);
        // a pin held high must not fire again
        u_host.wr(`DUC_OFS_CODE_FIRST | 7'h2, 16'h0666);
        settle();
        chk_ch(2, 1'b0, 1'b0, 12'h555);
        @(posedge clk_i);
        upd_pin <= 1'b0;
        $display("test sync done");
    endtask

    task automatic t_soft();
        int t;
        int ch;
        for (t = 0; t < 6; t++)
        begin
            u_host.wr(`DUC_OFS_SWCLAMP, 16'(1 << t));
            @(negedge clk_i);
            for (ch = 0; ch < 8; ch++)
                chk({15'h0, chan[ch].clamp}, {15'h0, tgt(ch) == t});
        end
        u_host.wr(`DUC_OFS_SWCLAMP, 16'h0001);
        u_host.wr(`DUC_OFS_CODE_FIRST, 16'h07a5);
        @(negedge clk_i);
        chk_ch(0, 1'b1, 1'b0, 12'habc);
        u_host.wr(`DUC_OFS_TRIG, 16'h0001);
        @(negedge clk_i);
        chk_ch(0, 1'b1, 1'b0, 12'h7a5);
        u_host.wr(`DUC_OFS_SWCLAMP, 16'h0000);
        @(negedge clk_i);
        chk_ch(0, 1'b0, 1'b0, 12'h7a5);
        $display("test soft clamp done");
    endtask

    task automatic t_fault();
        int ch;
        @(posedge clk_i);
        fault <= 1'b1;
        settle();
        for (ch = 0; ch < 8; ch++)
            chk({14'h0, chan[ch].clamp, chan[ch].rail}, {14'h0, ch < 4, ch < 4});
        @(posedge clk_i);
        fault <= 1'b0;
        settle();
        chk_ch(0, 1'b0, 1'b0, 12'h7a5);
        $display("test fault done");
    endtask

    task automatic t_standby();
        u_host.wr(`DUC_OFS_SB_A, 16'h0001);
        rchk(`DUC_OFS_SB_A, 16'h0001);
        @(posedge clk_i);
        sb_a <= 1'b1;
        settle();
        chk({13'h0, chan[0].clamp, chan[1].clamp, chan[2].clamp}, 16'h0006);
        chk({15'h0, amp_en}, 16'h0000);
        u_host.wr(`DUC_OFS_SWCLAMP, 16'h0002);
        rchk(`DUC_OFS_SWCLAMP, 16'h0002);
        u_host.wr(`DUC_OFS_SWCLAMP, 16'h0000);
        @(posedge clk_i);
        sb_a <= 1'b0;
        settle();
        chk({14'h0, chan[0].clamp, amp_en}, 16'h0001);
        $display("test standby done");
    endtask

    task automatic t_defer();
        u_host.wr(`DUC_OFS_SB_B, 16'h0084);
        @(posedge clk_i);
        sb_b <= 1'b1;
        settle();
        chk({15'h0, chan[4].clamp}, 16'h0001);
        // a release while the pin is live is ignored
        u_host.wr(`DUC_OFS_SWCLAMP, 16'h0000);
        @(posedge clk_i);
        sb_b <= 1'b0;
        settle();
        chk({15'h0, chan[4].clamp}, 16'h0001);
        u_host.wr(`DUC_OFS_SWCLAMP, 16'h0000);
        @(negedge clk_i);
        chk({15'h0, chan[4].clamp}, 16'h0000);
        $display("test deferred release done");
    endtask

    task automatic t_alarm();
        u_host.wr(`DUC_OFS_ALARM, 16'h0002);
        @(posedge clk_i);
        alarm <= 1'b1;
        settle();
        chk({13'h0, chan[2].clamp, chan[3].clamp, chan[0].clamp}, 16'h0006);
        @(posedge clk_i);
        alarm <= 1'b0;
        settle();
        chk({15'h0, chan[2].clamp}, 16'h0001);
        u_host.wr(`DUC_OFS_SWCLAMP, 16'h0000);
        @(negedge clk_i);
        chk_ch(2, 1'b0, 1'b0, 12'h666);
        $display("test alarm done");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        err_total = 0;
        total_checks = 0;
        rst_i = 1'b1;
        upd_pin = 1'b0;
        sb_a = 1'b0;
        sb_b = 1'b0;
        alarm = 1'b0;
        fault = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_async();
        t_sync();
        t_soft();
        t_fault();
        t_standby();
        t_defer();
        t_alarm();
        end_sim();
    end

endmodule
